// file: core/tpg_defs.svh
// Offsets, field positions, reset values and timing counts for the gate
// driver logic. Included by the package and by the core module.
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH

// Clock rate and boost timing
`define TPG_CLK_KHZ 20000
`define TPG_OFF_TIME_NS 5000
`define TPG_OFF_CYC ((`TPG_OFF_TIME_NS * `TPG_CLK_KHZ) / 1000000)
`define TPG_BLANK_TIME_NS 200
`define TPG_BLANK_CYC ((`TPG_BLANK_TIME_NS * `TPG_CLK_KHZ) / 1000000)

// Register byte offsets
`define TPG_ADR_STATUS 8'h00
`define TPG_ADR_CTRL 8'h04

// Reset value of the blanking field in the control register
`define TPG_CTRL_RST 8'h04

// Status register field positions
`define TPG_ST_HIGH 0
`define TPG_ST_LOW 3
`define TPG_ST_STG 6
`define TPG_ST_STB 9
`define TPG_ST_FAULT 12
`define TPG_ST_OV 13
`define TPG_ST_UV 14
`define TPG_ST_SHUT 15
`define TPG_ST_BOOST 16
`define TPG_ST_GATE_REGULATOR 17

`endif

// file: core/tpg_pkg.sv
// Types shared by the gate driver logic.
// Assumes tpg_defs.svh is on the include path.
`default_nettype none
`include "tpg_defs.svh"

package tpg_pkg;

    // Pin and comparator inputs, one sample
    typedef struct packed {
        logic en;
        logic [2:0] hi;
        logic [2:0] lo;
        logic [2:0] hs_vds;
        logic [2:0] ls_vds;
        logic bridge_open;
        logic bat_ov;
        logic bat_uv;
        logic gate_regulator_uv;
        logic vdd_uv;
        logic thermal;
        logic boost_ocp;
        logic boost_ov;
    } tpg_pins_t;

    // Boost switch control states
    typedef enum logic [2:0] {
        BST_IDLE = 3'h1,
        BST_ON = 3'h2,
        BST_HOLD = 3'h4
    } tpg_bst_t;

    // Whole module state
    typedef struct packed {
        tpg_pins_t s1;
        tpg_pins_t s2;
        logic [2:0] high_gate;
        logic [2:0] low_gate;
        logic [2:0] stg;
        logic [2:0] stb;
        logic fault_n;
        logic ov;
        logic uv;
        logic flag_oe;
        logic shut;
        logic gate_regulator_on;
        logic boost_sw;
        tpg_bst_t bst;
        logic [6:0] off;
        logic [7:0] blank;
        logic [7:0] ctrl;
        logic ack;
        logic [31:0] dat;
    } tpg_state_t;

endpackage

`default_nettype wire

// file: core/tpg_core.sv
// Digital control of a three-phase bridge gate driver with fault logic.
// Assumes comparator results arrive as asynchronous levels and that a
// classic Wishbone master on clk_i reaches the registers.
//
// What this block does
// - Fault low when an on transistor overloads.
// - High side vs drain, low side vs return.
// - Lead faults only reported, gates untouched.
// - Fault low on any supply or lead fault.
// - Battery flags follow hysteretic comparators.
// - Battery flags float on thermal or logic undervoltage.
// - Battery flags never both high.
// - Shutdown forces gates low, boost and regulator off.
// - Boost overcurrent forces fixed switch off-time.
// - Blank current limit after each switch turn-on.
// - Inhibit boost while its output is high.
// - Enable low forces all gates low.
// - Enable high maps commands to gates.
// - Both commands high turns both gates off.
// - Short-to-battery only with low gate on, enabled.
// - Short-to-ground with high gate on or open drain sense, enabled.
// - Open drain sense reads as ground short.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`default_nettype none
`include "tpg_defs.svh"

module tpg_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [2:0] high_side_cmd_i,
    input wire logic [2:0] low_side_cmd_i,
    input wire logic [2:0] high_vds_over_i,
    input wire logic [2:0] low_vds_over_i,
    input wire logic bridge_open_i,
    input wire logic bat_over_i,
    input wire logic bat_under_i,
    input wire logic gate_regulator_under_i,
    input wire logic logic_supply_under_i,
    input wire logic thermal_i,
    input wire logic boost_ocp_i,
    input wire logic boost_output_high_i,
    output logic [2:0] high_gate_out_o,
    output logic [2:0] low_gate_out_o,
    output logic fault_n_o,
    output logic battery_over_flag_o,
    output logic battery_over_flag_oe_o,
    output logic battery_under_flag_o,
    output logic battery_under_flag_oe_o,
    output logic boost_switch_o,
    output logic gate_regulator_on_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // Fixed off-time reload value; blanking reloads from the control register
    localparam logic [6:0] OFF_LOAD = 7'(`TPG_OFF_CYC - 1);

    // Gate pair for one phase: {high, low}
    function automatic logic [1:0] gate_map(input logic en,
        input logic hi, input logic lo, input logic shut);
        gate_map = (en && !shut) ? {hi & ~lo, lo & ~hi} : 2'h0;
    endfunction

    tpg_pkg::tpg_state_t q; // Registered state
    tpg_pkg::tpg_state_t next_q; // Next state
    tpg_pkg::tpg_pins_t pins; // Raw pin sample
    logic shut; // Shutdown condition
    logic hiz; // Battery flags float
    logic [2:0] stg; // Short-to-ground per phase
    logic [2:0] stb; // Short-to-battery per phase
    logic [1:0] pair; // Gate pair scratch

    // Gather raw inputs
    always_comb begin
        pins.en = enable_i;
        pins.hi = high_side_cmd_i;
        pins.lo = low_side_cmd_i;
        pins.hs_vds = high_vds_over_i;
        pins.ls_vds = low_vds_over_i;
        pins.bridge_open = bridge_open_i;
        pins.bat_ov = bat_over_i;
        pins.bat_uv = bat_under_i;
        pins.gate_regulator_uv = gate_regulator_under_i;
        pins.vdd_uv = logic_supply_under_i;
        pins.thermal = thermal_i;
        pins.boost_ocp = boost_ocp_i;
        pins.boost_ov = boost_output_high_i;
    end

    // Next state of the whole block
    always_comb begin
        next_q = q;
        // Two-stage synchroniser on every pin
        next_q.s1 = pins;
        next_q.s2 = q.s1;
        shut = q.s2.thermal | q.s2.vdd_uv | q.s2.bat_uv;
        hiz = q.s2.thermal | q.s2.vdd_uv;
        pair = 2'h0;
        // Command mapping per phase; only shutdown enters here, lead faults do not
        for (int i = 0; i < 3; i++) begin
            pair = gate_map(q.s2.en, q.s2.hi[i], q.s2.lo[i],
                shut);
            next_q.high_gate[i] = pair[1];
            next_q.low_gate[i] = pair[0];
        end
        // Drain-source checks against the gates now driven
        stb = q.low_gate & q.s2.ls_vds & {3{q.s2.en}};
        stg = ((q.high_gate & q.s2.hs_vds) | {3{q.s2.bridge_open}})
            & {3{q.s2.en}};
        next_q.stg = stg;
        next_q.stb = stb;
        // Summary fault, active low
        next_q.fault_n = !((|stb) || (|stg) || q.s2.bat_ov
            || q.s2.bat_uv || q.s2.gate_regulator_uv || q.s2.vdd_uv
            || q.s2.thermal);
        // Battery flags follow the hysteretic comparators
        next_q.ov = q.s2.bat_ov & ~hiz;
        next_q.uv = q.s2.bat_uv & ~q.s2.bat_ov & ~hiz;
        next_q.flag_oe = ~hiz;
        next_q.shut = shut;
        next_q.gate_regulator_on = ~shut;
        // Boost switch control
        case (q.bst)
            tpg_pkg::BST_IDLE: begin
                // Start a new pulse when allowed
                if (!shut && !q.s2.boost_ov) begin
                    next_q.bst = tpg_pkg::BST_ON;
                    next_q.blank = q.ctrl;
                end
            end
            tpg_pkg::BST_ON: begin
                if (shut || q.s2.boost_ov) begin
                    next_q.bst = tpg_pkg::BST_IDLE;
                end else if (q.blank != 8'h00) begin
                    next_q.blank = q.blank - 8'h01;
                end else if (q.s2.boost_ocp) begin
                    next_q.bst = tpg_pkg::BST_HOLD;
                    next_q.off = OFF_LOAD;
                end
            end
            tpg_pkg::BST_HOLD: begin
                // Count down the off-time
                if (q.off == 7'h00) begin
                    next_q.bst = tpg_pkg::BST_IDLE;
                end else begin
                    next_q.off = q.off - 7'h01;
                end
            end
            default: begin
                next_q.bst = tpg_pkg::BST_IDLE;
            end
        endcase
        next_q.boost_sw = (next_q.bst == tpg_pkg::BST_ON);
        // Wishbone slave, one answer per request, ack registered one cycle after the strobe
        next_q.ack = wb_cyc_i & wb_stb_i & ~q.ack;
        next_q.dat = 32'h0000_0000;
        if (wb_cyc_i && wb_stb_i && !q.ack) begin
            if (wb_adr_i == `TPG_ADR_CTRL) begin
                next_q.dat = {24'h00_0000, q.ctrl};
            end else if (wb_adr_i == `TPG_ADR_STATUS) begin
                next_q.dat[`TPG_ST_HIGH +: 3] = q.high_gate;
                next_q.dat[`TPG_ST_LOW +: 3] = q.low_gate;
                next_q.dat[`TPG_ST_STG +: 3] = q.stg;
                next_q.dat[`TPG_ST_STB +: 3] = q.stb;
                next_q.dat[`TPG_ST_FAULT] = ~q.fault_n;
                next_q.dat[`TPG_ST_OV] = q.ov;
                next_q.dat[`TPG_ST_UV] = q.uv;
                next_q.dat[`TPG_ST_SHUT] = q.shut;
                next_q.dat[`TPG_ST_BOOST] = q.boost_sw;
                next_q.dat[`TPG_ST_GATE_REGULATOR] = q.gate_regulator_on;
            end
        end
        // Write lands on the edge where the master samples ack high
        if (wb_cyc_i && wb_stb_i && q.ack && wb_we_i && wb_sel_i[0]
            && wb_adr_i == `TPG_ADR_CTRL) begin
            next_q.ctrl = wb_dat_i[7:0];
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.fault_n <= 1'b1;
            q.bst <= tpg_pkg::BST_IDLE;
            q.ctrl <= `TPG_CTRL_RST;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flip-flops
    assign high_gate_out_o = q.high_gate;
    assign low_gate_out_o = q.low_gate;
    assign fault_n_o = q.fault_n;
    assign battery_over_flag_o = q.ov;
    assign battery_over_flag_oe_o = q.flag_oe;
    assign battery_under_flag_o = q.uv;
    assign battery_under_flag_oe_o = q.flag_oe;
    assign boost_switch_o = q.boost_sw;
    assign gate_regulator_on_o = q.gate_regulator_on;
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;

    // Checks on the driven outputs
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_enable_low_gates: assert property (
        !q.s2.en |=> (high_gate_out_o == 3'h0) && (low_gate_out_o == 3'h0))
        else $error("Gates on while enable low");
    a_no_shoot_through: assert property (
        (q.s2.hi & q.s2.lo) != 3'h0 |=>
        ((high_gate_out_o | low_gate_out_o) & $past(q.s2.hi & q.s2.lo))
        == 3'h0)
        else $error("Gate on with both commands high");
    a_command_map: assert property (
        q.s2.en && !shut |=> high_gate_out_o == $past(q.s2.hi & ~q.s2.lo)
        && low_gate_out_o == $past(q.s2.lo & ~q.s2.hi))
        else $error("Gate mapping wrong");
    a_shutdown_off: assert property (
        shut |=> high_gate_out_o == 3'h0 && low_gate_out_o == 3'h0
        && !gate_regulator_on_o && !boost_switch_o)
        else $error("Output active during shutdown");
    a_lead_fault_low: assert property (
        (stg | stb) != 3'h0 |=> !fault_n_o)
        else $error("Lead fault not reported");
    a_supply_fault_low: assert property (
        q.s2.bat_ov || q.s2.gate_regulator_uv || q.s2.thermal |=> !fault_n_o)
        else $error("Supply fault not reported");
    a_stb_needs_gate: assert property (
        $rose(q.stb[0]) |-> $past(low_gate_out_o[0]) && $past(q.s2.en))
        else $error("Short-to-battery without low gate");
    a_flags_exclusive: assert property (
        !(battery_over_flag_o && battery_under_flag_o))
        else $error("Both battery flags high");
    a_flags_float: assert property (
        hiz |=> !battery_over_flag_oe_o && !battery_under_flag_oe_o
        && !battery_over_flag_o)
        else $error("Battery flags driven during float");
    a_off_time_hold: assert property (
        q.bst == tpg_pkg::BST_HOLD && q.off == OFF_LOAD |->
        !boost_switch_o [*8])
        else $error("Boost switch on during off-time");
    a_off_count: assert property (
        q.bst == tpg_pkg::BST_HOLD && q.off != 7'h00 |=>
        q.bst == tpg_pkg::BST_HOLD && q.off == $past(q.off) - 7'h01)
        else $error("Off-time counter not running");
    a_blank_ignore: assert property (
        q.bst == tpg_pkg::BST_ON && q.blank != 8'h00 |=>
        q.bst != tpg_pkg::BST_HOLD)
        else $error("Current limit seen during blanking");
    a_boost_inhibit: assert property (
        q.s2.boost_ov |=> !boost_switch_o)
        else $error("Boost switch on while output high");

    // A new pulse always starts with the blanking count loaded
    a_blank_loaded: assert property (
        q.bst == tpg_pkg::BST_IDLE && !shut && !q.s2.boost_ov |=>
        q.bst == tpg_pkg::BST_ON && q.blank == $past(q.ctrl))
        else $error("Blanking count not loaded");
    // Ground short needs a driven high gate or an open drain sense
    a_stg_needs_gate: assert property (
        $rose(q.stg[0]) |-> $past(q.s2.en)
        && ($past(high_gate_out_o[0]) || $past(q.s2.bridge_open)))
        else $error("Short-to-ground without high gate");
    // Open drain sense marks every phase
    a_open_all_phases: assert property (
        q.s2.bridge_open && q.s2.en |=> q.stg == 3'h7)
        else $error("Open drain sense not on all phases");
    // Flags follow their comparators unless floating
    a_over_flag_set: assert property (
        q.s2.bat_ov && !hiz |=> battery_over_flag_o)
        else $error("Over flag missing");
    a_under_flag_set: assert property (
        q.s2.bat_uv && !q.s2.bat_ov && !hiz |=> battery_under_flag_o)
        else $error("Under flag missing");
    // Regulator runs whenever no shutdown cause is present
    a_regulator_on: assert property (
        !shut |=> gate_regulator_on_o)
        else $error("Regulator off without shutdown");
    // Summary fault releases once every cause is gone
    a_fault_release: assert property (
        (stg | stb) == 3'h0 && !q.s2.bat_ov && !q.s2.bat_uv
        && !q.s2.gate_regulator_uv && !q.s2.vdd_uv && !q.s2.thermal |=> fault_n_o)
        else $error("Fault held without cause");

    c_shoot_cmd: cover property (q.s2.en && (q.s2.hi & q.s2.lo) != 3'h0);
    c_off_time: cover property (q.bst == tpg_pkg::BST_HOLD);
    c_lead_fault: cover property (q.stg != 3'h0 && !fault_n_o);
    c_shutdown: cover property (shut && !battery_over_flag_oe_o);
    c_boost_inhibit: cover property (q.s2.boost_ov
        && q.bst == tpg_pkg::BST_IDLE);

endmodule

`default_nettype wire

// file: bench/tpg_ctl_model.sv
// Model of the outside motor controller that drives the command pins.
// Assumes the bench puts the wanted pin levels on want_i.
`default_nettype none

module tpg_ctl_model (
    input wire logic clk_i,
    input wire logic [6:0] want_i, // {enable, low, high}
    input wire logic fault_n_i,
    output logic enable_o,
    output logic [2:0] high_o,
    output logic [2:0] low_o,
    output logic [15:0] faults_o // Cycles with fault seen low
);
    timeunit 1ns;
    timeprecision 1ns;

    // Known pin levels from time zero
    initial begin
        {enable_o, low_o, high_o, faults_o} = 23'h0;
    end

    // Pins change just after the edge, like a clocked controller
    always @(posedge clk_i) begin
        {enable_o, low_o, high_o} <= want_i;
    end

    // Fault lows are only counted; the commands never react to them
    always @(posedge clk_i) begin
        if (fault_n_i === 1'b0) begin
            faults_o <= faults_o + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// file: bench/tpg_core_tb.sv
// Self-checking bench for the three-phase gate driver logic.
// Assumes tpg_core and the controller model are compiled before it.
`default_nettype none

module tpg_core_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i, rst_i, en, bop, bov, buv, vru, vdu, thm, ocp, bsh;
    logic [6:0] want; // Wanted command pins
    logic [2:0] hi, lo, hv, lv, hg, lg;
    logic cyc, stb, we, ack, fn, ovf, ovoe, uvf, uvoe, bsw, reg_on;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] faults;
    int bad_count, samples_checked;

    tpg_ctl_model ctl (.clk_i(clk_i), .want_i(want), .fault_n_i(fn),
        .enable_o(en), .high_o(hi), .low_o(lo), .faults_o(faults));

    tpg_core uut (.clk_i(clk_i), .rst_i(rst_i), .enable_i(en),
        .high_side_cmd_i(hi), .low_side_cmd_i(lo), .high_vds_over_i(hv),
        .low_vds_over_i(lv), .bridge_open_i(bop), .bat_over_i(bov),
        .bat_under_i(buv), .gate_regulator_under_i(vru),
        .logic_supply_under_i(vdu), .thermal_i(thm), .boost_ocp_i(ocp),
        .boost_output_high_i(bsh), .high_gate_out_o(hg),
        .low_gate_out_o(lg), .fault_n_o(fn), .battery_over_flag_o(ovf),
        .battery_over_flag_oe_o(ovoe), .battery_under_flag_o(uvf),
        .battery_under_flag_oe_o(uvoe), .boost_switch_o(bsw),
        .gate_regulator_on_o(reg_on), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Room for the two sync stages and the output register
    task automatic settle();
        repeat (8) @(posedge clk_i);
    endtask

    task automatic set(input logic e, input logic [2:0] h,
                       input logic [2:0] l);
        want <= {e, l, h};
        settle();
    endtask

    // One classic Wishbone cycle; read data lands in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, s, d};
        // Hold the request until ack is sampled high; the watchdog
        // ends a wait that never sees one
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'h0;
        @(posedge clk_i);
        // The slave drops ack in the cycle after it gave it
        check(ack, 1'b0);
    endtask

    // Cycles that the boost switch stays at level v
    task automatic span(input logic v, output int n);
        n = 0;
        while (bsw === v && n < 400) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic t_logic();
        logic [2:0] h, l;
        for (int j = 0; j < 128; j++) begin
            h = j[2:0];
            l = j[5:3];
            set(j[6], h, l);
            check(hg, {3{j[6]}} & h & ~l);
            check(lg, {3{j[6]}} & l & ~h);
            check(fn, 1'b1);
        end
        $display("test logic done");
    endtask

    task automatic t_lead();
        set(1'b1, 3'h1, 3'h2);
        hv <= 3'h1;
        settle();
        check({fn, hg, lg}, 7'h0A);
        hv <= 3'h2;
        settle();
        check(fn, 1'b1);
        lv <= 3'h2;
        settle();
        check(fn, 1'b0);
        lv <= 3'h1;
        settle();
        check(fn, 1'b1);
        {bop, lv} <= 4'hA;
        set(1'b0, 3'h1, 3'h2);
        check(fn, 1'b1);
        set(1'b1, 3'h1, 3'h2);
        check(fn, 1'b0);
        wb(1'b0, 8'h00, 4'hF, 32'h0);
        check(q[12:0], 13'h15D1);
        check(faults != 16'h0000, 1'b1);
        {bop, hv, lv} <= 7'h00;
        settle();
        $display("test lead done");
    endtask

    task automatic t_supply();
        logic [4:0] f;
        logic fl;
        for (int k = 0; k < 5; k++) begin
            f = 5'h01 << k;
            {thm, vdu, vru, buv, bov} <= f;
            settle();
            fl = f[4] | f[3];
            check(fn, 1'b0);
            check({ovf, uvf}, {f[0] & ~fl, f[1] & ~fl});
            check({ovoe, uvoe}, {2{~fl}});
            check({hg, reg_on}, (fl | f[1]) ? 4'h0 : 4'h3);
            if (fl | f[1]) check(bsw, 1'b0);
        end
        {thm, vdu, vru, buv, bov} <= 5'h03;
        settle();
        check(ovf & uvf, 1'b0);
        {thm, vdu, vru, buv, bov} <= 5'h00;
        settle();
        check({fn, ovf, uvf}, 3'h4);
        $display("test supply done");
    endtask

    task automatic t_boost();
        int n;
        wb(1'b0, 8'h04, 4'hF, 32'h0);
        check(q, 32'h04);
        wb(1'b1, 8'h04, 4'hE, 32'h40);
        wb(1'b1, 8'h08, 4'hF, 32'hFF);
        wb(1'b0, 8'h08, 4'hF, 32'h0);
        check(q, 32'h00);
        wb(1'b0, 8'h04, 4'hF, 32'h0);
        check(q, 32'h04);
        wb(1'b1, 8'h04, 4'hF, 32'h40);
        ocp <= 1'b1;
        span(1'b1, n);
        span(1'b0, n);
        check(n >= 100 && n <= 110, 1'b1);
        span(1'b1, n);
        check(n >= 64 && n <= 72, 1'b1);
        ocp <= 1'b0;
        // Let the off-time run out so the switch is on again
        span(1'b0, n);
        check(bsw, 1'b1);
        bsh <= 1'b1;
        settle();
        check(bsw, 1'b0);
        bsh <= 1'b0;
        settle();
        wb(1'b0, 8'h00, 4'hF, 32'h0);
        check(q[17:16], 2'h3);
        $display("test boost done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Free-running clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Main sequence
    initial begin
        rst_i = 1'b1;
        {want, hv, lv, cyc, stb, we, adr, sel, wdat} = 60'h0;
        {bop, bov, buv, vru, vdu, thm, ocp, bsh} = 8'h00;
        bad_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk_i);
        check({fn, hg, lg, ovoe, reg_on, ack}, 10'h200);
        rst_i <= 1'b0;
        settle();
        $display("test reset done");
        t_logic();
        t_lead();
        t_supply();
        t_boost();
        final_report();
    end

    // Watchdog at 20000 cycles, far beyond the under two thousand cycles the tests need
    initial begin
        #(50 * 20000);
        bad_count++;
        final_report();
    end
endmodule

`default_nettype wire
